// >>> hw/srr_pkg.sv
package srr_pkg;

  // Serial command word
  localparam int CMD_W   = 29;
  localparam int RB_W    = 24;
  localparam int ZERO_W  = 5;
  localparam int CNT_W   = 6;
  localparam int RW_BIT  = 28;
  localparam int CH_HI   = 27;
  localparam int CH_LO   = 24;
  localparam int MODE_HI = 23;
  localparam int MODE_LO = 22;
  localparam int DATA_HI = 21;
  localparam int ADDR_HI = 21;
  localparam int ADDR_LO = 16;
  localparam int VAL_HI  = 15;
  localparam logic [CNT_W-1:0] LONG_FRAME  = 6'h1d;
  localparam logic [CNT_W-1:0] SHORT_FRAME = 6'h18;

  // Register select field
  localparam logic [1:0] SEL_PMU    = 2'h0;
  localparam logic [1:0] SEL_GAIN   = 2'h1;
  localparam logic [1:0] SEL_OFFSET = 2'h2;
  localparam logic [1:0] SEL_INPUT  = 2'h3;

  // Comparator level DAC address ranges
  localparam logic [5:0] CMP_LOW_FIRST  = 6'h21;
  localparam logic [5:0] CMP_LOW_LAST   = 6'h25;
  localparam logic [5:0] CMP_HIGH_FIRST = 6'h28;
  localparam logic [5:0] CMP_HIGH_LAST  = 6'h2d;

  // Host timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS  = 80;
  localparam int HALF_CYC      = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);

  // Host register map, byte addresses
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_CTRL     = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_RDATA    = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam int CTRL_START = 0;
  localparam int CTRL_SHORT = 1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic srr_one_hot(input logic [3:0] ch);
    return (ch != 4'h0) && ((ch & (ch - 4'h1)) == 4'h0);
  endfunction : srr_one_hot

  function automatic logic [1:0] srr_ch_index(input logic [3:0] ch);
    return ch[3] ? 2'h3 : ch[2] ? 2'h2 : ch[1] ? 2'h1 : 2'h0;
  endfunction : srr_ch_index

  function automatic logic srr_dac_valid(input logic [5:0] a);
    return (a >= CMP_LOW_FIRST && a <= CMP_LOW_LAST) || (a >= CMP_HIGH_FIRST && a <= CMP_HIGH_LAST);
  endfunction : srr_dac_valid

endpackage : srr_pkg

// >>> hw/srr_link_if.sv
`timescale 1ns/1ps
interface srr_link_if;
  logic sclk;    // Serial clock, made by the host
  logic sync_n;  // Frame select, low during a frame
  logic sdi;     // Host to device data
  logic sdo;     // Device to host data

  modport device (input sclk, input sync_n, input sdi, output sdo);
  modport host   (output sclk, output sync_n, output sdi, input sdo);
endinterface : srr_link_if

// >>> hw/srr_device.sv
`timescale 1ns/1ps
module srr_device
  import srr_pkg::*;
(
  input  wire logic       REF_CLK,        // System clock
  input  wire logic       RESET_N,        // Synchronous reset
  input  wire logic       CE,             // Clock enable
  input  wire logic [7:0] COMP_STATUS,    // Comparator flags, same clock
  input  wire logic [7:0] ALARM_STATUS,   // Alarm flags, same clock
  output logic      [21:0] SYS_CTRL,      // System control register
  output logic            CMD_STROBE,     // One pulse per decoded command
  srr_link_if.device      LINK            // Serial link
);

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0]           sclk_s;
    logic [2:0]           sync_s;
    logic [1:0]           sdi_s;
    logic [CMD_W-1:0]     shreg;
    logic [CNT_W-1:0]     cnt;
    logic                 sdo;
    logic [21:0]          sys_ctrl;
    logic [3:0][21:0]     pmu;
    logic                 strobe;
  } srr_dev_state_type;

  srr_dev_state_type state_reg;
  srr_dev_state_type state_next;

  // DAC levels per channel, address and select; kept here as the device's own memory
  logic [15:0] dac_mem [0:1023];
  logic        mem_we;
  logic [9:0]  mem_waddr;
  logic [15:0] mem_wdata;

  logic             sclk_rise;
  logic             frame_on;
  logic             frame_start;
  logic             frame_end;
  logic [CMD_W-1:0] cmd;
  logic [3:0]       ch;
  logic [1:0]       sel;
  logic [5:0]       addr;
  logic [RB_W-1:0]  rb;
  logic [9:0]       ridx;

  //////////////////////////////////////////////////////////////////////////////
  // Only the second and third stages are looked at; the first only feeds the second
  assign sclk_rise   = state_reg.sclk_s[1] & ~state_reg.sclk_s[2];
  assign frame_on    = ~state_reg.sync_s[1];
  assign frame_start = ~state_reg.sync_s[1] & state_reg.sync_s[2];
  assign frame_end   = state_reg.sync_s[1] & ~state_reg.sync_s[2];
  assign cmd  = state_reg.shreg;
  assign ch   = cmd[CH_HI:CH_LO];
  assign sel  = cmd[MODE_HI:MODE_LO];
  assign addr = cmd[ADDR_HI:ADDR_LO];
  assign ridx = {srr_ch_index(ch), addr, sel};

  // Readback selection
  always_comb begin
    rb = '0;
    if (ch == 4'h0) begin
      case (sel)
        SEL_PMU:   rb = (cmd[DATA_HI:0] == 22'h0) ? {2'h0, state_reg.sys_ctrl} : '0;
        SEL_GAIN:  rb = {16'h0000, COMP_STATUS};
        SEL_INPUT: rb = {16'h0000, ALARM_STATUS};
        default:   rb = '0;
      endcase
    end else if (srr_one_hot(ch)) begin
      if (sel == SEL_PMU) begin
        rb = {2'h0, state_reg.pmu[srr_ch_index(ch)]};
      end else if (srr_dac_valid(addr)) begin
        rb = {8'h00, dac_mem[ridx]};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    mem_we     = 1'b0;
    mem_waddr  = ridx;
    mem_wdata  = cmd[VAL_HI:0];
    state_next.strobe = 1'b0;
    state_next.sclk_s = {state_reg.sclk_s[1:0], LINK.sclk};
    state_next.sync_s = {state_reg.sync_s[1:0], LINK.sync_n};
    state_next.sdi_s  = {state_reg.sdi_s[0], LINK.sdi};
    // One shift engine serves both frame lengths; the five extra edges of a long frame shift the readback
    if (frame_start) begin
      state_next.cnt = '0;
      state_next.sdo = state_reg.shreg[CMD_W-1];
    end else if (frame_on && sclk_rise) begin
      state_next.shreg = {state_reg.shreg[CMD_W-2:0], state_reg.sdi_s[1]};
      state_next.sdo   = state_reg.shreg[CMD_W-2];
      if (state_reg.cnt != LONG_FRAME) begin
        state_next.cnt = state_reg.cnt + 6'h01;
      end
    end else if (frame_end && (state_reg.cnt == LONG_FRAME || state_reg.cnt == SHORT_FRAME)) begin
      // A long frame also shifts out the five zeros that were below the readback
      state_next.strobe = 1'b1;
      state_next.shreg  = '0;
      if (cmd[RW_BIT]) begin
        state_next.shreg = {rb, {ZERO_W{1'b0}}};
      end else if (ch == 4'h0) begin
        if (sel == SEL_PMU) begin
          state_next.sys_ctrl = cmd[DATA_HI:0];
        end
      end else if (srr_one_hot(ch)) begin
        if (sel == SEL_PMU) begin
          state_next.pmu[srr_ch_index(ch)] = cmd[DATA_HI:0];
        end else if (srr_dac_valid(addr)) begin
          mem_we = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      state_reg <= '{sclk_s: 3'h0, sync_s: 3'h7, sdi_s: 2'h0, shreg: '0, cnt: '0, sdo: 1'b0,
                     sys_ctrl: '0, pmu: '0, strobe: 1'b0};
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  // No reset on the level memory; contents are undefined until written
  always_ff @(posedge REF_CLK) begin
    if (CE && mem_we) begin
      dac_mem[mem_waddr] <= mem_wdata;
    end
  end

  assign LINK.sdo   = state_reg.sdo;
  assign SYS_CTRL   = state_reg.sys_ctrl;
  assign CMD_STROBE = state_reg.strobe;

endmodule : srr_device

// >>> hw/srr_host.sv
`timescale 1ns/1ps
module srr_host
  import srr_pkg::*;
(
  input  wire logic        REF_CLK,        // System clock
  input  wire logic        RESET_N,        // Synchronous reset
  input  wire logic        CE,             // Clock enable
  input  wire logic [7:0]  S_AXI_AWADDR,   // Write address
  input  wire logic        S_AXI_AWVALID,  // Write address valid
  output logic             S_AXI_AWREADY,  // Write address ready
  input  wire logic [31:0] S_AXI_WDATA,    // Write data
  input  wire logic [3:0]  S_AXI_WSTRB,    // Write strobes
  input  wire logic        S_AXI_WVALID,   // Write data valid
  output logic             S_AXI_WREADY,   // Write data ready
  output logic [1:0]       S_AXI_BRESP,    // Write response
  output logic             S_AXI_BVALID,   // Write response valid
  input  wire logic        S_AXI_BREADY,   // Write response ready
  input  wire logic [7:0]  S_AXI_ARADDR,   // Read address
  input  wire logic        S_AXI_ARVALID,  // Read address valid
  output logic             S_AXI_ARREADY,  // Read address ready
  output logic [31:0]      S_AXI_RDATA,    // Read data
  output logic [1:0]       S_AXI_RRESP,    // Read response
  output logic             S_AXI_RVALID,   // Read data valid
  input  wire logic        S_AXI_RREADY,   // Read data ready
  output logic             IRQ,            // Interrupt, high level
  srr_link_if.host         LINK            // Serial link
);

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOW  = 3'b001,
    ST_HIGH = 3'b010,
    ST_TAIL = 3'b011
  } srr_host_st_type;

  typedef struct packed {
    srr_host_st_type  st;
    logic [3:0]       tick;
    logic [CNT_W-1:0] left;
    logic [CMD_W-1:0] tx;
    logic [RB_W-1:0]  rx;
    logic [1:0]       sdo_s;
    logic             sclk;
    logic             sync_n;
    logic [CMD_W-1:0] cmd;
    logic [RB_W-1:0]  rdata;
    logic             irq_stat;
    logic             irq_mask;
    logic             irq;
    logic             awready;
    logic             wready;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata_bus;
    logic [1:0]       rresp;
  } srr_host_state_type;

  srr_host_state_type s_reg;
  srr_host_state_type s_next;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic done;
    logic aw_ok;
    done  = 1'b0;
    aw_ok = 1'b0;
    s_next = s_reg;
    s_next.sdo_s = {s_reg.sdo_s[0], LINK.sdo};
    // Serial engine: data changes after the falling edge, sdo sampled before the rising one
    case (s_reg.st)
      ST_IDLE: begin
      end
      ST_LOW: begin
        s_next.tick = s_reg.tick + 4'h1;
        if (s_reg.tick == HALF_LAST) begin
          s_next.tick = '0;
          s_next.rx   = {s_reg.rx[RB_W-2:0], s_reg.sdo_s[1]};
          s_next.sclk = 1'b1;
          s_next.st   = ST_HIGH;
        end
      end
      ST_HIGH: begin
        s_next.tick = s_reg.tick + 4'h1;
        if (s_reg.tick == HALF_LAST) begin
          s_next.tick = '0;
          s_next.sclk = 1'b0;
          s_next.tx   = {s_reg.tx[CMD_W-2:0], 1'b0};
          s_next.left = s_reg.left - 6'h01;
          s_next.st   = (s_reg.left == 6'h01) ? ST_TAIL : ST_LOW;
        end
      end
      ST_TAIL: begin
        s_next.tick = s_reg.tick + 4'h1;
        if (s_reg.tick == HALF_LAST) begin
          s_next.tick   = '0;
          s_next.sync_n = 1'b1;
          s_next.rdata  = s_reg.rx;
          done          = 1'b1;
          s_next.st     = ST_IDLE;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase

    // AXI4-Lite write: address and data taken in either order, answer after both
    if (S_AXI_AWVALID && s_reg.awready) begin
      s_next.awaddr  = S_AXI_AWADDR;
      s_next.awready = 1'b0;
    end
    if (S_AXI_WVALID && s_reg.wready) begin
      s_next.wdata  = S_AXI_WDATA;
      s_next.wstrb  = S_AXI_WSTRB;
      s_next.wready = 1'b0;
    end
    if (!s_reg.awready && !s_reg.wready && !s_reg.bvalid) begin
      s_next.bvalid = 1'b1;
      s_next.bresp  = RESP_OKAY;
      aw_ok = 1'b1;
      case (s_reg.awaddr)
        OFS_CMD: begin
          // Partial strobes are honoured so the top byte may be left alone
          for (int b = 0; b < 4; b++) begin
            if (s_reg.wstrb[b]) begin
              s_next.cmd[b*8 +: 8] = s_reg.wdata[b*8 +: 8];
            end
          end
        end
        OFS_CTRL: begin
          // Start is ignored while a frame runs; software polls busy
          if (s_reg.wstrb[0] && s_reg.wdata[CTRL_START] && s_reg.st == ST_IDLE) begin
            s_next.sync_n = 1'b0;
            s_next.tick   = '0;
            s_next.st     = ST_LOW;
            // A short frame sends the low 24 bits; flush with all ones for a no-op
            s_next.tx   = s_reg.wdata[CTRL_SHORT] ? {s_reg.cmd[RB_W-1:0], {ZERO_W{1'b0}}} : s_reg.cmd;
            s_next.left = s_reg.wdata[CTRL_SHORT] ? SHORT_FRAME : LONG_FRAME;
          end
        end
        OFS_IRQ_STAT: begin
          if (s_reg.wstrb[0] && s_reg.wdata[0]) begin
            s_next.irq_stat = 1'b0;
          end
        end
        OFS_IRQ_MASK: begin
          if (s_reg.wstrb[0]) begin
            s_next.irq_mask = s_reg.wdata[0];
          end
        end
        OFS_STATUS, OFS_RDATA: begin
        end
        default: s_next.bresp = RESP_SLVERR;
      endcase
    end
    if (s_reg.bvalid && S_AXI_BREADY) begin
      s_next.bvalid  = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready  = 1'b1;
    end

    // AXI4-Lite read
    if (S_AXI_ARVALID && s_reg.arready) begin
      s_next.arready = 1'b0;
      s_next.rvalid  = 1'b1;
      s_next.rresp   = RESP_OKAY;
      s_next.rdata_bus = '0;
      case (S_AXI_ARADDR)
        OFS_CMD:      s_next.rdata_bus = {3'h0, s_reg.cmd};
        OFS_CTRL:     s_next.rdata_bus = '0;
        OFS_STATUS:   s_next.rdata_bus = {31'h0, s_reg.st != ST_IDLE};
        OFS_RDATA:    s_next.rdata_bus = {8'h00, s_reg.rdata};
        OFS_IRQ_STAT: s_next.rdata_bus = {31'h0, s_reg.irq_stat};
        OFS_IRQ_MASK: s_next.rdata_bus = {31'h0, s_reg.irq_mask};
        default:      s_next.rresp = RESP_SLVERR;
      endcase
    end
    if (s_reg.rvalid && S_AXI_RREADY) begin
      s_next.rvalid  = 1'b0;
      s_next.arready = 1'b1;
    end

    // Frame done sets after the clear so a coincident event is kept
    if (done) begin
      s_next.irq_stat = 1'b1;
    end
    s_next.irq = s_next.irq_stat & s_next.irq_mask;
    if (!aw_ok) begin
      s_next.bresp = s_next.bvalid ? s_next.bresp : RESP_OKAY;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      s_reg         <= '0;
      s_reg.st      <= ST_IDLE;
      s_reg.sync_n  <= 1'b1;
      s_reg.awready <= 1'b1;
      s_reg.wready  <= 1'b1;
      s_reg.arready <= 1'b1;
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  assign LINK.sclk     = s_reg.sclk;
  assign LINK.sync_n   = s_reg.sync_n;
  assign LINK.sdi      = s_reg.tx[CMD_W-1];
  assign S_AXI_AWREADY = s_reg.awready;
  assign S_AXI_WREADY  = s_reg.wready;
  assign S_AXI_BVALID  = s_reg.bvalid;
  assign S_AXI_BRESP   = s_reg.bresp;
  assign S_AXI_ARREADY = s_reg.arready;
  assign S_AXI_RVALID  = s_reg.rvalid;
  assign S_AXI_RDATA   = s_reg.rdata_bus;
  assign S_AXI_RRESP   = s_reg.rresp;
  assign IRQ           = s_reg.irq;

endmodule : srr_host

// >>> verif/srr_link_checker.sv
`timescale 1ns/1ps
module srr_link_checker (
  input wire logic REF_CLK,    // System clock
  input wire logic RESET_N,    // Sync reset
  input wire logic sclk,       // Serial clock
  input wire logic sync_n,     // Frame select
  input wire logic sdi,        // Host data
  input wire logic sdo,        // Device data
  input wire logic CMD_STROBE  // Decode pulse
);
  logic [5:0] edge_cnt;
  logic       sclk_q;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  ////////////////////////////////////////
  // Cleared between frames, so the count at frame end is the frame length
  always_ff @(posedge REF_CLK) begin
    sclk_q <= sclk;
    if (!RESET_N || sync_n) begin
      edge_cnt <= 6'h0;
    end else if (sclk && !sclk_q) begin
      edge_cnt <= edge_cnt + 6'h1;
    end
  end

  ////////////////////////////////////////
  chk_clock_idle: assert property (sync_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  chk_frame_lead: assert property ($fell(sync_n) |-> !sclk [*8])
    else $error("first serial edge too early");
  chk_high_time: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high time wrong");
  chk_low_time: assert property ($fell(sclk) && !sync_n |-> !sclk [*8])
    else $error("serial clock low time wrong");
  chk_sdi_hold: assert property (sclk |-> $stable(sdi))
    else $error("host data moved while clock high");
  chk_sdo_settled: assert property ($rose(sclk) |-> $stable(sdo))
    else $error("device data moved at sampling edge");
  chk_edge_count: assert property ($rose(sync_n) |-> edge_cnt == 6'h18 || edge_cnt == 6'h1d)
    else $error("frame length neither 24 nor 29");
  chk_strobe_after: assert property ($rose(sync_n) |-> ##[1:12] CMD_STROBE)
    else $error("no decode after frame");
  chk_strobe_pulse: assert property (CMD_STROBE |-> sync_n ##1 !CMD_STROBE)
    else $error("decode pulse malformed");

  cover property ($rose(sync_n) && edge_cnt == 6'h18);
  cover property ($rose(sync_n) && edge_cnt == 6'h1d);
  cover property (CMD_STROBE);
endmodule : srr_link_checker

// >>> verif/test_serial_register_readback.sv
`timescale 1ns/1ps
module test_serial_register_readback;
  import srr_pkg::*;
  logic        clk, rst_n, ce, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, strobe, sclk_q, ok;
  logic [7:0]  comp, alarm, awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, resp;
  logic [21:0] sys_ctrl;
  logic [28:0] cap;
  int          error_cnt, compares;

  srr_link_if srr_link_if_i ();
  srr_device srr_device_i (.REF_CLK(clk), .RESET_N(rst_n), .CE(ce), .COMP_STATUS(comp),
    .ALARM_STATUS(alarm), .SYS_CTRL(sys_ctrl), .CMD_STROBE(strobe), .LINK(srr_link_if_i));
  srr_host srr_host_i (.REF_CLK(clk), .RESET_N(rst_n), .CE(ce), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .IRQ(irq), .LINK(srr_link_if_i));
  srr_link_checker srr_link_checker_i (.REF_CLK(clk), .RESET_N(rst_n), .sclk(srr_link_if_i.sclk),
    .sync_n(srr_link_if_i.sync_n), .sdi(srr_link_if_i.sdi), .sdo(srr_link_if_i.sdo), .CMD_STROBE(strobe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // What the host saw on the data line, one bit per rising serial edge
  always @(posedge clk) begin
    sclk_q <= srr_link_if_i.sclk;
    if (!srr_link_if_i.sync_n && srr_link_if_i.sclk && !sclk_q) begin
      cap <= {cap[27:0], srr_link_if_i.sdo};
    end
  end

  ////////////////////////////////////////
  task end_sim;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task timeout(input string nm);
    error_cnt++;
    $display("MISMATCH %s expected answer seen timeout", nm);
    end_sim();
  endtask : timeout

  task axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
    end while (!bvalid && n < 200);
    resp = bresp;
    if (n >= 200) timeout("axi write");
  endtask : axw

  task axr(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b0;
    end while (!rvalid && n < 200);
    rd = rdata;
    resp = rresp;
    if (n >= 200) timeout("axi read");
  endtask : axr

  // Sends one frame; optionally compares what came back during it
  task frame(input logic [28:0] c, input logic sh, input logic chk, input logic [23:0] e);
    int n;
    axw(OFS_CMD, {3'h0, c});
    axw(OFS_CTRL, {30'h0, sh, 1'b1});
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) timeout("frame done");
    if (chk) begin
      axr(OFS_RDATA);
      check("readback", rd, {8'h0, e});
    end
    axw(OFS_IRQ_STAT, 32'h1);
  endtask : frame

  ////////////////////////////////////////
  initial begin
    int          i;
    logic [5:0]  a;
    logic [15:0] v;
    logic [28:0] fl;
    fl = 29'h0ffffff;
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 48'h0;
    ce = 1'b1;
    comp = 8'h5a;
    alarm = 8'ha5;
    error_cnt = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("irq after reset", {31'h0, irq}, 32'h0);
    axr(8'h40);
    check("unmapped rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    axw(8'h40, 32'h1);
    check("unmapped bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    axw(OFS_IRQ_MASK, 32'h1);
    // Sweep past both ends of each level range; gaps must stay unmapped
    for (i = 0; i < 15; i++) begin
      a = 6'h20 + 6'(i);
      v = {10'h2b7, a};
      ok = (a >= CMP_LOW_FIRST && a <= CMP_LOW_LAST) || (a >= CMP_HIGH_FIRST && a <= CMP_HIGH_LAST);
      frame({1'b0, 4'h1 << (i % 4), 2'(i % 3 + 1), a, v}, 1'b0, 1'b0, 24'h0);
      frame({1'b1, 4'h1 << (i % 4), 2'(i % 3 + 1), a, 16'h0}, 1'b0, 1'b1, 24'h0);
      frame(fl, 1'b1, 1'b1, ok ? {8'h0, v} : 24'h0);
    end
    frame({1'b1, 4'h0, SEL_GAIN, 22'h0}, 1'b0, 1'b0, 24'h0);
    // A long frame keeps the last 24 bits seen, so the readback lands shifted over the five zeros
    frame({1'b1, 4'h0, SEL_INPUT, 22'h0}, 1'b0, 1'b1, {11'h0, comp, 5'h0});
    check("sdo word", {3'h0, cap}, {11'h0, comp, 5'h0});
    frame(fl, 1'b1, 1'b1, {16'h0, alarm});
    frame({1'b1, 4'h3, SEL_GAIN, 6'h21, 16'h0}, 1'b0, 1'b0, 24'h0);
    frame(fl, 1'b1, 1'b1, 24'h0);
    frame({1'b1, 4'h0, SEL_OFFSET, 22'h3fffff}, 1'b0, 1'b0, 24'h0);
    frame(fl, 1'b1, 1'b1, 24'h0);
    frame({1'b0, 4'h0, SEL_PMU, 22'h2a5a5}, 1'b0, 1'b0, 24'h0);
    check("system control", {10'h0, sys_ctrl}, 32'h2a5a5);
    frame({1'b1, 4'h0, SEL_PMU, 22'h0}, 1'b0, 1'b0, 24'h0);
    frame(fl, 1'b1, 1'b1, 24'h2a5a5);
    check("flush left control", {10'h0, sys_ctrl}, 32'h2a5a5);
    // Masked event must stay sticky yet silent until unmasked
    axw(OFS_IRQ_MASK, 32'h0);
    axw(OFS_CMD, {3'h0, fl});
    axw(OFS_CTRL, 32'h3);
    i = 0;
    do begin
      axr(OFS_IRQ_STAT);
      i++;
    end while (rd[0] !== 1'b1 && i < 500);
    if (i >= 500) timeout("masked event");
    check("masked irq", {31'h0, irq}, 32'h0);
    axr(OFS_STATUS);
    check("busy", rd, 32'h0);
    axw(OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    check("unmasked irq", {31'h0, irq}, 32'h1);
    axw(OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    check("cleared irq", {31'h0, irq}, 32'h0);
    end_sim();
  end
endmodule : test_serial_register_readback
